// file: hw/ecr_range_flags.v
// Range, wrap, index and compare flags of an encoder counter unit.
// Assumes the counters and their count strobes come from logic on
// pclk; software reaches the registers over APB.
//
// Operation
// R01: Range flag with its enable set raises the interrupt.
// R02: Full range: flag on down 0001 to 0000 or up fffe to ffff.
// R03: Half range: flag on down 8001 to 8000 or up 7ffe to 7fff.
// R04: Width select 0 picks range 0000-ffff, 1 picks 8000-7fff.
// R05: Flags clear only on written 0; written 1 leaves them alone. A 1 written at offset 24 (ECR_OFF_IRQ_CLEAR) also clears them.
// R06: Read-modify-write reads return 1 in every flag bit.
// R07: Reserved control bits 15 to 3 read zero; software writes 0.
// R08: Index flag sets when the index input resets the position.
// R09: No index flag in gate mode or in wrap-only revolution mode.
// R10: Overflow flag sets on up-count at the maximum position.
// R11: Underflow flag sets on down-count at position zero.
// R12: Wrap/index enable raises interrupt for overflow/underflow/index.
// R13: Source select 0: shared match on position equal to compare.
// R14: Source select 1: shared match on revolution equal to compare.
// R15: Shared match flag with its enable raises the interrupt.
// R16: Position match flag sets on compare equal; enable raises irq.
// R17: All enables, flags and modes reset to zero. The irq_en_r mask resets to 3f instead.
// R18: A set event beats a clearing write in the same cycle.
`timescale 1ns/10ps
`include "ecr_defs.vh"

module ecr_range_flags (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] pos_count,
  input  wire [15:0] rev_count,
  input  wire        pos_up,
  input  wire        pos_down,
  input  wire        rev_up,
  input  wire        rev_down,
  input  wire        pos_reset_by_index,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Byte-lane merge for 16-bit registers
  // ----------------------------------------------------------------
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8],
                 strb[0] ? data[7:0]  : old[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // Address match, plain or through the read-modify-write alias
  // ----------------------------------------------------------------
  function hit2;
    input [7:0] addr;
    input [7:0] base;
    input [7:0] alias_addr;
    begin
      hit2 = (addr == base) || (addr == alias_addr);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg                     width_sel_r;
  reg                     range_en_r;
  reg                     wrap_en_r;
  reg                     shr_en_r;
  reg                     pos_en_r;
  reg  [3:0]              cnt_ctrl_r;
  reg  [15:0]             max_pos_r;
  reg  [15:0]             shr_cmp_r;
  reg  [15:0]             pos_cmp_r;
  reg  [`ECR_NUM_SRC-1:0] flag_r;
  reg  [`ECR_NUM_SRC-1:0] irq_en_r;
  reg                     shr_eq_r;
  reg                     pos_eq_r;

  reg  [`ECR_NUM_SRC-1:0] flag_nxt;
  reg  [`ECR_NUM_SRC-1:0] set_v;
  reg  [`ECR_NUM_SRC-1:0] clr_v;
  reg  [`ECR_NUM_SRC-1:0] src_en;
  reg  [31:0]             rd_nxt;
  reg                     err_nxt;

  wire setup   = psel & ~penable;
  wire wr_acc  = psel & penable & pready & pwrite;
  wire lane0   = wr_acc & pstrb[0];
  wire src_rev = cnt_ctrl_r[`ECR_CC_SRC_SEL];
  wire gate_md = cnt_ctrl_r[`ECR_CC_GATE_SEL];
  wire [1:0] rev_mode = cnt_ctrl_r[`ECR_CC_MODE_HI:`ECR_CC_MODE_LO];

  // ----------------------------------------------------------------
  // Write decode, qualified by the access cycle
  // ----------------------------------------------------------------
  // Narrow registers need lane 0; the 16-bit ones merge per lane
  wire wr_rng = lane0 & hit2(paddr, `ECR_OFF_RANGE_CTRL,
                             `ECR_OFF_RANGE_RMW);
  wire wr_int = lane0 & hit2(paddr, `ECR_OFF_INT_CTRL_LOW,
                             `ECR_OFF_INT_RMW);
  wire wr_cc  = lane0 & (paddr == `ECR_OFF_COUNTER_CTRL);
  wire wr_clr = lane0 & (paddr == `ECR_OFF_IRQ_CLEAR);
  wire wr_ien = lane0 & (paddr == `ECR_OFF_IRQ_ENABLE);
  wire wr_max = wr_acc & (paddr == `ECR_OFF_MAX_POS);
  wire wr_shr = wr_acc & (paddr == `ECR_OFF_SHARED_CMP);
  wire wr_pcm = wr_acc & (paddr == `ECR_OFF_POS_CMP);

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Half range moves both edges; the choice is one mux per edge
  wire [15:0] dn_from = width_sel_r ? `ECR_HALF_DN_FROM
                                    : `ECR_FULL_DN_FROM; // R04
  wire [15:0] up_from = width_sel_r ? `ECR_HALF_UP_FROM
                                    : `ECR_FULL_UP_FROM; // R04
  wire range_ev = (rev_down & (rev_count == dn_from)) |
                  (rev_up & (rev_count == up_from)); // R02 R03
  wire index_ev = pos_reset_by_index & ~gate_md &
                  (rev_mode != `ECR_MODE_WRAP_ONLY); // R08 R09
  wire ovf_ev   = pos_up & (pos_count == max_pos_r); // R10
  wire unf_ev   = pos_down & (pos_count == `ECR_POS_ZERO); // R11
  wire shr_eq   = src_rev ? (rev_count == shr_cmp_r)
                          : (pos_count == shr_cmp_r); // R13 R14
  wire pos_eq   = (pos_count == pos_cmp_r); // R16
  // Entry into equality sets the flag, so a clear sticks while equal
  wire shr_ev   = shr_eq & ~shr_eq_r;
  wire pos_ev   = pos_eq & ~pos_eq_r;

  // ----------------------------------------------------------------
  // Flag set and clear
  // ----------------------------------------------------------------
  always @* begin
    set_v = {`ECR_NUM_SRC{1'b0}};
    set_v[`ECR_ST_RANGE]     = range_ev;
    set_v[`ECR_ST_INDEX]     = index_ev;
    set_v[`ECR_ST_OVERFLOW]  = ovf_ev;
    set_v[`ECR_ST_UNDERFLOW] = unf_ev;
    set_v[`ECR_ST_SHARED]    = shr_ev;
    set_v[`ECR_ST_POSITION]  = pos_ev;
    clr_v = {`ECR_NUM_SRC{1'b0}};
    if (wr_rng) begin
      clr_v[`ECR_ST_RANGE] = ~pwdata[`ECR_RC_FLAG]; // R05
    end
    if (wr_int) begin
      clr_v[`ECR_ST_INDEX]     = ~pwdata[`ECR_IC_INDEX_FLAG]; // R05
      clr_v[`ECR_ST_OVERFLOW]  = ~pwdata[`ECR_IC_OVERFLOW_FLAG];
      clr_v[`ECR_ST_UNDERFLOW] = ~pwdata[`ECR_IC_UNDERFLOW_FLAG];
      clr_v[`ECR_ST_SHARED]    = ~pwdata[`ECR_IC_SHR_MATCH_FLAG];
      clr_v[`ECR_ST_POSITION]  = ~pwdata[`ECR_IC_POS_MATCH_FLAG];
    end
    if (wr_clr) begin
      clr_v = clr_v | pwdata[`ECR_NUM_SRC-1:0];
    end
    flag_nxt = set_v | (flag_r & ~clr_v); // R18
  end

  // ----------------------------------------------------------------
  // Interrupt source gating
  // ----------------------------------------------------------------
  always @* begin
    src_en = {`ECR_NUM_SRC{1'b0}};
    src_en[`ECR_ST_RANGE]     = range_en_r; // R01
    src_en[`ECR_ST_INDEX]     = wrap_en_r; // R12
    src_en[`ECR_ST_OVERFLOW]  = wrap_en_r;
    src_en[`ECR_ST_UNDERFLOW] = wrap_en_r;
    src_en[`ECR_ST_SHARED]    = shr_en_r; // R15
    src_en[`ECR_ST_POSITION]  = pos_en_r; // R16
  end

  // ----------------------------------------------------------------
  // Read mux, sampled in the setup cycle
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      `ECR_OFF_RANGE_CTRL, `ECR_OFF_RANGE_RMW: begin
        rd_nxt[`ECR_RC_WIDTH_SEL] = width_sel_r; // R07
        rd_nxt[`ECR_RC_FLAG]      = flag_r[`ECR_ST_RANGE] |
                                    (paddr == `ECR_OFF_RANGE_RMW); // R06
        rd_nxt[`ECR_RC_IRQ_EN]    = range_en_r;
      end
      `ECR_OFF_INT_CTRL_LOW, `ECR_OFF_INT_RMW: begin
        rd_nxt[`ECR_IC_POS_MATCH_EN]   = pos_en_r;
        rd_nxt[`ECR_IC_SHR_MATCH_EN]   = shr_en_r;
        rd_nxt[`ECR_IC_WRAP_IDX_EN]    = wrap_en_r;
        rd_nxt[`ECR_IC_POS_MATCH_FLAG] = flag_r[`ECR_ST_POSITION];
        rd_nxt[`ECR_IC_SHR_MATCH_FLAG] = flag_r[`ECR_ST_SHARED];
        rd_nxt[`ECR_IC_UNDERFLOW_FLAG] = flag_r[`ECR_ST_UNDERFLOW];
        rd_nxt[`ECR_IC_OVERFLOW_FLAG]  = flag_r[`ECR_ST_OVERFLOW];
        rd_nxt[`ECR_IC_INDEX_FLAG]     = flag_r[`ECR_ST_INDEX];
        if (paddr == `ECR_OFF_INT_RMW) begin
          rd_nxt[`ECR_IC_POS_MATCH_FLAG] = 1'b1; // R06
          rd_nxt[`ECR_IC_SHR_MATCH_FLAG] = 1'b1;
          rd_nxt[`ECR_IC_UNDERFLOW_FLAG] = 1'b1;
          rd_nxt[`ECR_IC_OVERFLOW_FLAG]  = 1'b1;
          rd_nxt[`ECR_IC_INDEX_FLAG]     = 1'b1;
        end
      end
      `ECR_OFF_COUNTER_CTRL: rd_nxt[3:0] = cnt_ctrl_r;
      `ECR_OFF_MAX_POS:      rd_nxt[15:0] = max_pos_r;
      `ECR_OFF_SHARED_CMP:   rd_nxt[15:0] = shr_cmp_r;
      `ECR_OFF_POS_CMP:      rd_nxt[15:0] = pos_cmp_r;
      `ECR_OFF_IRQ_STATUS:   rd_nxt[`ECR_NUM_SRC-1:0] = flag_r;
      `ECR_OFF_IRQ_CLEAR:    rd_nxt = 32'h0000_0000;
      `ECR_OFF_IRQ_ENABLE:   rd_nxt[`ECR_NUM_SRC-1:0] = irq_en_r;
      default:               err_nxt = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // APB handshake: one access cycle, no wait states
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup & err_nxt;
      if (setup && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and equality history
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r   <= {`ECR_NUM_SRC{1'b0}}; // R17
      shr_eq_r <= 1'b0;
      pos_eq_r <= 1'b0;
    end else if (clk_en) begin
      flag_r   <= flag_nxt; // R18
      shr_eq_r <= shr_eq;
      pos_eq_r <= pos_eq;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Registered, so irq lags its flag by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(flag_r & src_en & irq_en_r); // R01 R12 R15 R16
    end
  end

  // ----------------------------------------------------------------
  // Range control
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_sel_r <= 1'b0; // R17
      range_en_r  <= 1'b0;
    end else if (clk_en) begin
      if (wr_rng) begin
        width_sel_r <= pwdata[`ECR_RC_WIDTH_SEL]; // R04
        range_en_r  <= pwdata[`ECR_RC_IRQ_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control enables
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_en_r  <= 1'b0; // R17
      shr_en_r  <= 1'b0;
      wrap_en_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_int) begin
        pos_en_r  <= pwdata[`ECR_IC_POS_MATCH_EN];
        shr_en_r  <= pwdata[`ECR_IC_SHR_MATCH_EN];
        wrap_en_r <= pwdata[`ECR_IC_WRAP_IDX_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ctrl_r <= 4'h0; // R17
    end else if (clk_en) begin
      if (wr_cc) begin
        cnt_ctrl_r <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable mask
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= `ECR_RST_IRQ_EN;
    end else if (clk_en) begin
      if (wr_ien) begin
        irq_en_r <= pwdata[`ECR_NUM_SRC-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Maximum position
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_pos_r <= 16'h0000;
    end else if (clk_en) begin
      if (wr_max) begin
        max_pos_r <= merge16(max_pos_r, pwdata[15:0], pstrb[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared compare
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shr_cmp_r <= 16'h0000;
    end else if (clk_en) begin
      if (wr_shr) begin
        shr_cmp_r <= merge16(shr_cmp_r, pwdata[15:0], pstrb[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Position compare
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cmp_r <= 16'h0000;
    end else if (clk_en) begin
      if (wr_pcm) begin
        pos_cmp_r <= merge16(pos_cmp_r, pwdata[15:0], pstrb[1:0]);
      end
    end
  end

endmodule

// file: hw/ecr_defs.vh
// Constants for the encoder range and interrupt flag block.
// Assumes inclusion by bare name from the design file only.
`ifndef ECR_DEFS_VH
`define ECR_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ECR_OFF_RANGE_CTRL    8'h00
`define ECR_OFF_INT_CTRL_LOW  8'h04
`define ECR_OFF_RANGE_RMW     8'h08
`define ECR_OFF_INT_RMW       8'h0c
`define ECR_OFF_COUNTER_CTRL  8'h10
`define ECR_OFF_MAX_POS       8'h14
`define ECR_OFF_SHARED_CMP    8'h18
`define ECR_OFF_POS_CMP       8'h1c
`define ECR_OFF_IRQ_STATUS    8'h20
`define ECR_OFF_IRQ_CLEAR     8'h24
`define ECR_OFF_IRQ_ENABLE    8'h28

// ----------------------------------------------------------------
// Field positions, extension range control
// ----------------------------------------------------------------
`define ECR_RC_WIDTH_SEL   0
`define ECR_RC_FLAG        1
`define ECR_RC_IRQ_EN      2

// ----------------------------------------------------------------
// Field positions, interrupt control low
// ----------------------------------------------------------------
`define ECR_IC_POS_MATCH_EN    0
`define ECR_IC_POS_MATCH_FLAG  1
`define ECR_IC_SHR_MATCH_EN    2
`define ECR_IC_SHR_MATCH_FLAG  3
`define ECR_IC_WRAP_IDX_EN     4
`define ECR_IC_UNDERFLOW_FLAG  5
`define ECR_IC_OVERFLOW_FLAG   6
`define ECR_IC_INDEX_FLAG      7

// ----------------------------------------------------------------
// Counter control fields and sticky status bit positions
// ----------------------------------------------------------------
`define ECR_CC_SRC_SEL     0
`define ECR_CC_GATE_SEL    1
`define ECR_CC_MODE_LO     2
`define ECR_CC_MODE_HI     3
`define ECR_MODE_WRAP_ONLY 2'b10
`define ECR_ST_RANGE       0
`define ECR_ST_INDEX       1
`define ECR_ST_OVERFLOW    2
`define ECR_ST_UNDERFLOW   3
`define ECR_ST_SHARED      4
`define ECR_ST_POSITION    5
`define ECR_NUM_SRC        6

// ----------------------------------------------------------------
// Range boundary values and reset values
// ----------------------------------------------------------------
`define ECR_FULL_DN_FROM   16'h0001
`define ECR_FULL_UP_FROM   16'hfffe
`define ECR_HALF_DN_FROM   16'h8001
`define ECR_HALF_UP_FROM   16'h7ffe
`define ECR_POS_ZERO       16'h0000
`define ECR_RST_CTRL       16'h0000
`define ECR_RST_IRQ_EN     6'h3f

`endif

// file: testbench/ecr_range_flags_chk.sv
// Port-level checker for the encoder range and flag block.
// Assumes a bind from the bench top file; one clock domain.
`timescale 1ns/10ps
module ecr_range_flags_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] pos_count,
  input wire logic [15:0] rev_count,
  input wire logic        pos_up,
  input wire logic        pos_down,
  input wire logic        rev_up,
  input wire logic        rev_down,
  input wire logic        pos_reset_by_index,
  input wire logic        irq
);
  logic [31:0] cnt_q;
  logic        ev;
  logic        wr;
  // Count changes count as causes too: match flags follow equality
  always_ff @(posedge pclk) cnt_q <= {pos_count, rev_count};
  assign wr = psel & penable & pwrite;
  assign ev = pos_up | pos_down | rev_up | rev_down | pos_reset_by_index
            | wr | ({pos_count, rev_count} != cnt_q);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable && clk_en |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err;
    pready && paddr > 8'h28 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_rsvd;
    pready && !pwrite && paddr[7:4] == 4'h0 && paddr[2:0] == 3'h0
      |-> prdata[31:3] == 29'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_rmw_rng; pready && !pwrite && paddr == 8'h08 |-> prdata[1];
  endproperty
  a_rmw_rng: assert property (p_rmw_rng) else $error("rmw range");
  property p_rmw_int;
    pready && !pwrite && paddr == 8'h0c |-> &{prdata[7:5], prdata[3],
                                              prdata[1]};
  endproperty
  a_rmw_int: assert property (p_rmw_int) else $error("rmw int");
  property p_rise; $rose(irq) |-> $past(ev, 2) || $past(ev, 3); endproperty
  a_rise: assert property (p_rise) else $error("irq no cause");
  property p_fall; $fell(irq) |-> $past(wr, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq fell alone");
  property p_rst; $rose(presetn) |-> !irq && !pready; endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
endmodule

// file: testbench/ecr_encoder_model.sv
// Encoder side: counter values, one-cycle strobes, index resets.
// Assumes the bench calls ev; changes follow rising pclk edges.
`timescale 1ns/10ps
module ecr_encoder_model (
  input  wire logic        pclk,
  output      logic [15:0] pos_count,
  output      logic [15:0] rev_count,
  output      logic        pos_up,
  output      logic        pos_down,
  output      logic        rev_up,
  output      logic        rev_down,
  output      logic        pos_reset_by_index
);
  initial begin
    pos_count = 16'h2222;
    rev_count = 16'h1111;
    {pos_reset_by_index, rev_down, rev_up, pos_down, pos_up} = 5'h00;
  end
  // Strobe shows the pre-count value; counts move on afterwards
  task automatic ev(input logic [15:0] pc, rc, input logic [4:0] s,
                    input int dly);
    repeat (dly) @(posedge pclk);
    pos_count <= pc;
    rev_count <= rc;
    {pos_reset_by_index, rev_down, rev_up, pos_down, pos_up} <= s;
    @(posedge pclk);
    {pos_reset_by_index, rev_down, rev_up, pos_down, pos_up} <= 5'h00;
    pos_count <= s[4] ? 16'h0000 : pc + {15'h0, s[0]} - {15'h0, s[1]};
    rev_count <= rc + {15'h0, s[2]} - {15'h0, s[3]};
  endtask
endmodule

// file: testbench/tb_ecr_range_flags.sv
// Bench: APB master, table of count events, then hand-written cases.
// Assumes the encoder model drives the count side of the block.
`timescale 1ns/10ps
module tb_ecr_range_flags;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err;
  logic [15:0] pos_count, rev_count;
  logic        pos_up, pos_down, rev_up, rev_down, pos_reset_by_index;
  int          failures = 0;
  int          num_checks = 0;
  // wsel, ctrl, strobes, pos, rev, expected status
  localparam logic [55:0] rows [16] = '{
    56'h0_0_04_2222_fffe_01, 56'h0_0_08_2222_0001_01,
    56'h1_0_04_2222_7ffe_01, 56'h1_0_08_2222_8001_01,
    56'h0_0_04_2222_7ffe_00, 56'h1_0_04_2222_fffe_00,
    56'h0_0_01_0100_1111_04, 56'h0_0_01_00ff_1111_00,
    56'h0_0_02_0000_1111_08, 56'h0_0_10_2222_1111_02,
    56'h0_2_10_2222_1111_00, 56'h0_8_10_2222_1111_00,
    56'h0_0_00_0050_1111_10, 56'h0_1_00_2222_0050_10,
    56'h0_1_00_0050_1111_00, 56'h0_0_00_0030_1111_20};
  always #5 pclk = ~pclk;
  ecr_range_flags i_ecr_range_flags (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_count(pos_count),
    .rev_count(rev_count), .pos_up(pos_up), .pos_down(pos_down),
    .rev_up(rev_up), .rev_down(rev_down),
    .pos_reset_by_index(pos_reset_by_index), .irq(irq));
  ecr_encoder_model i_ecr_encoder_model (.pclk(pclk),
    .pos_count(pos_count), .rev_count(rev_count), .pos_up(pos_up),
    .pos_down(pos_down), .rev_up(rev_up), .rev_down(rev_down),
    .pos_reset_by_index(pos_reset_by_index));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("failures %0d checks %0d", failures, num_checks);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    #300us;
    failures++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h14, 32'h100);
    apb(1'b1, 8'h18, 32'h50);
    apb(1'b1, 8'h1c, 32'h30);
    for (int i = 0; i < 16; i++) begin
      i_ecr_encoder_model.ev(16'h2222, 16'h1111, 5'h00, 0);
      apb(1'b1, 8'h00, {29'h0, 2'b11, rows[i][52]});
      apb(1'b1, 8'h10, {28'h0, rows[i][51:48]});
      apb(1'b1, 8'h04, 32'hff);
      apb(1'b1, 8'h24, 32'h3f);
      i_ecr_encoder_model.ev(rows[i][39:24], rows[i][23:8],
                             rows[i][44:40], 0);
      apb(1'b0, 8'h20, 32'h0);
      chk("status", rd, {24'h0, rows[i][7:0]});
      chk("irq", {31'h0, irq}, {31'h0, |rows[i][7:0]});
    end
    // Second reset in mid-run, then the awkward cases
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("range_ctrl", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("int_ctrl", rd, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk("irq_enable", rd, 32'h3f);
    // Keep the compares off zero so the index reset below matches none
    apb(1'b1, 8'h18, 32'h50);
    apb(1'b1, 8'h1c, 32'h30);
    i_ecr_encoder_model.ev(16'h2222, 16'hfffe, 5'h04, 0);
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b0, 8'h00, 32'h0);
    chk("range_keep", rd, 32'h6);
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h00, 32'h0);
    chk("range_clear", rd, 32'h4);
    chk("irq_off", {31'h0, irq}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("range_rmw", rd, 32'h6);
    // Index reset lands on the edge of a clearing write
    fork
      apb(1'b1, 8'h04, 32'h7f);
      i_ecr_encoder_model.ev(16'h2222, 16'h1111, 5'h10, 2);
    join
    apb(1'b0, 8'h04, 32'h0);
    chk("set_wins", rd, 32'h95);
    apb(1'b1, 8'h04, 32'h15);
    apb(1'b0, 8'h0c, 32'h0);
    chk("int_rmw", rd, 32'hff);
    apb(1'b0, 8'h04, 32'h0);
    chk("int_clear", rd, 32'h15);
    // Enable low: a range event must be ignored
    clk_en <= 1'b0;
    i_ecr_encoder_model.ev(16'h2222, 16'hfffe, 5'h04, 0);
    clk_en <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk("frozen", rd, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    end_of_test;
  end
endmodule
bind ecr_range_flags ecr_range_flags_chk i_chk (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pos_count(pos_count), .rev_count(rev_count),
  .pos_up(pos_up), .pos_down(pos_down), .rev_up(rev_up),
  .rev_down(rev_down), .pos_reset_by_index(pos_reset_by_index),
  .irq(irq));
